// ==== hdl/pidc_defs.svh ====
// Purpose: Register offsets, codes, reset values and timing figures of the PID controller.
// Assumes: Included by bare name; definitions only.
// Notes: Signal percent values use 0.01 % units, so 100 % is 10000; gain and gain scale use 0.1 % units, so 100 % is 1000.
`ifndef PIDC_DEFS_SVH
`define PIDC_DEFS_SVH
`define PIDC_A_REF_SEL   8'h00
`define PIDC_A_FB_SEL    8'h04
`define PIDC_A_KEY_REF   8'h08
`define PIDC_A_P_GAIN    8'h0C
`define PIDC_A_P_SCALE   8'h10
`define PIDC_A_I_TIME    8'h14
`define PIDC_A_D_TIME    8'h18
`define PIDC_A_MFI_CFG   8'h1C
`define PIDC_A_STATUS    8'h20
`define PIDC_A_OUT       8'h24
`define PIDC_SRC_KEYPAD  4'h0
`define PIDC_SRC_V1      4'h1
`define PIDC_SRC_V2      4'h3
`define PIDC_SRC_I2      4'h4
`define PIDC_SRC_RS485   4'h5
`define PIDC_SRC_OPT     4'h7
`define PIDC_SRC_USEQ    4'h9
`define PIDC_SRC_PULSE   4'hB
`define PIDC_MFI_ICLR    5'h15
`define PIDC_MFI_NONE    3'h7
`define PIDC_PCT_FULL    32'h00002710
`define PIDC_GAIN_MAX    16'h2710
`define PIDC_SCALE_MAX   16'h03E8
`define PIDC_GAIN_DIV    48'sh0000000F4240
`define PIDC_RST_FB_SEL  4'h1
`define PIDC_RST_GAIN    16'h01F4
`define PIDC_RST_SCALE   16'h03E8
`define PIDC_RST_I_TIME  16'h03E8
`define PIDC_RST_D_TIME  16'h0000
`define PIDC_CLK_MHZ     40
`define PIDC_TICK_US     1000
`define PIDC_GATE_US     100000
`define PIDC_US_PER_S    1000000
`define PIDC_PULSE_FS_HZ 32000
`endif

// ==== hdl/pidc_pkg.sv ====
// Purpose: Shared types of the PID controller.
// Assumes: Codes come from pidc_defs.svh.
// Notes: None.
`include "pidc_defs.svh"
package pidc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SUM  = 2'b10
  } pidc_state_t;
endpackage

// ==== hdl/pidc_divider.sv ====
// Purpose: Unsigned restoring divider, one quotient bit per clock.
// Assumes: Dividend and divisor are stable at start.
// Notes: A zero divisor gives no true quotient; each quotient bit is the inverse of remainder bit DW-1.
`timescale 1ns/1ps
module pidc_divider
  import pidc_pkg::*;
#(
  parameter int NW = 32,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  output logic      [NW-1:0] quotient,
  output logic               done
);
  localparam int CW = $clog2(NW + 1);
  logic [DW:0]   rem_ff;
  logic [NW-1:0] quo_ff;
  logic [DW-1:0] div_ff;
  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic          done_ff;
  wire  [DW:0]   shifted = {rem_ff[DW-1:0], quo_ff[NW-1]};
  wire  [DW:0]   diff    = shifted - {1'b0, div_ff};
  wire           qbit    = ~diff[DW];
  wire           last    = (cnt_ff == CW'(NW - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      div_ff  <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      rem_ff  <= '0;
      quo_ff  <= dividend;
      div_ff  <= divisor;
      cnt_ff  <= '0;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      rem_ff  <= qbit ? diff : shifted;
      quo_ff  <= {quo_ff[NW-2:0], qbit};
      cnt_ff  <= cnt_ff + 1'b1;
      busy_ff <= ~last;
      done_ff <= last;
    end else begin
      done_ff <= 1'b0;
    end
  end
  assign quotient = quo_ff;
  assign done     = done_ff;
endmodule

// ==== hdl/pidc_pulse_meter.sv ====
// Purpose: Measures the pulse-train input rate as a percentage of full scale.
// Assumes: The pulse input is synchronous to clk.
// Notes: Full scale is FS_CNT edges in one gate period; faster input reads 100 %.
`timescale 1ns/1ps
`include "pidc_defs.svh"
module pidc_pulse_meter
  import pidc_pkg::*;
#(
  parameter int GATE_CYC = 4000000,
  parameter int FS_CNT   = 3200
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pulse_in,
  output logic      [15:0] pct
);
  localparam int GW = $clog2(GATE_CYC);
  logic [GW-1:0] gate_ff;
  logic [15:0]   cnt_ff;
  logic [15:0]   pct_ff;
  logic          prev_ff;
  wire           rise     = pulse_in & ~prev_ff;
  wire           gate_end = (gate_ff == GW'(GATE_CYC - 1));
  wire           at_fs    = (cnt_ff >= 16'(FS_CNT));
  wire  [31:0]   scaled   = (32'(cnt_ff) * `PIDC_PCT_FULL) / 32'(FS_CNT);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_ff <= '0;
      cnt_ff  <= 16'h0000;
      pct_ff  <= 16'h0000;
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pulse_in;
      gate_ff <= gate_end ? '0 : gate_ff + 1'b1;
      if (gate_end) begin
        cnt_ff <= {15'h0000, rise};
        pct_ff <= scaled[15:0];
      end else if (rise && !at_fs) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
  assign pct = pct_ff;
endmodule

// ==== hdl/pidc_top.sv ====
// Purpose: Process PID controller with APB register access.
// Assumes: Source inputs are signed percentages with 100 % = 10000, synchronous to clk.
// Notes: One control period is one millisecond tick; times are in milliseconds.
// Function
// - Reference selector 0 takes the keypad reference register, other values ignore it.
// - Reference selector 5 is the RS-485 input, 7 the option card and 9 the user sequence.
// - Reference selector 11 is the pulse-train input, measured from 0 to 32 kHz.
// - The feedback selector offers the reference choices except the keypad.
// - A feedback selector write equal to the current reference source is refused.
// - The proportional term is the error times the proportional gain percentage.
// - Proportional gain spans 0.0 to 1000.0 % and a gain scale reduces it further.
// - A steady 100 % error brings the integral term to 100 % after the integral time.
// - A multi-function input set to code 21 clears the integral accumulator.
// - The derivative term is the error change per period times the derivative time.
`timescale 1ns/1ps
`include "pidc_defs.svh"
module pidc_top
  import pidc_pkg::*;
#(
  parameter int TICK_CYC = `PIDC_CLK_MHZ * `PIDC_TICK_US,
  parameter int GATE_CYC = `PIDC_CLK_MHZ * `PIDC_GATE_US,
  parameter int MFI_N    = 7
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic        [7:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic       [31:0] pwdata,
  output logic            [31:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic signed [15:0] first_voltage_input,
  input  wire logic signed [15:0] second_voltage_input,
  input  wire logic signed [15:0] current_input,
  input  wire logic signed [15:0] serial_input,
  input  wire logic signed [15:0] option_card_source,
  input  wire logic signed [15:0] user_sequence_source,
  input  wire logic              pulse_train_input,
  input  wire logic  [MFI_N-1:0] mfi_in,
  output logic signed     [31:0] pid_out,
  output logic                   pid_valid
);
  localparam int TW     = $clog2(TICK_CYC);
  localparam int FS_CNT = `PIDC_PULSE_FS_HZ * (`PIDC_GATE_US / `PIDC_TICK_US) / (`PIDC_US_PER_S / `PIDC_TICK_US);

  logic        [3:0]  reference_selector_param_ff;
  logic        [3:0]  feedback_selector_param_ff;
  logic signed [15:0] keypad_ref_ff;
  logic        [15:0] proportional_gain_ff;
  logic        [15:0] gain_scale_ff;
  logic        [15:0] integral_time_ff;
  logic        [15:0] derivative_time_ff;
  logic        [2:0]  mfi_term_ff;
  logic        [4:0]  mfi_func_ff;
  logic               refused_ff;
  logic        [31:0] prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;
  logic        [TW-1:0] tcnt_ff;
  logic               tick_ff;
  pidc_state_t        st_ff;
  pidc_state_t        nxt_st;
  logic signed [16:0] err_prev_ff;
  logic signed [31:0] acc_ff;
  logic signed [47:0] p_term_ff;
  logic signed [47:0] i_term_ff;
  logic signed [47:0] d_term_ff;
  logic               neg_ff;
  logic        [15:0] itime_go_ff;
  logic        [31:0] amag_go_ff;
  logic signed [31:0] pid_out_ff;
  logic               valid_ff;
  logic        [15:0] pulse_pct;
  logic        [31:0] quo;
  logic               div_done;
  logic signed [15:0] src_tab [0:15];

  function automatic logic src_ok(input logic [3:0] s);
    case (s)
      `PIDC_SRC_KEYPAD, `PIDC_SRC_V1, `PIDC_SRC_V2, `PIDC_SRC_I2,
      `PIDC_SRC_RS485, `PIDC_SRC_OPT, `PIDC_SRC_USEQ, `PIDC_SRC_PULSE: src_ok = 1'b1;
      default: src_ok = 1'b0;
    endcase
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [49:0] v);
    if (v > 50'sh0007FFFFFFF) begin
      sat32 = 32'sh7FFFFFFF;
    end else if (v < -50'sh00080000000) begin
      sat32 = 32'sh80000000;
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  pidc_pulse_meter #(.GATE_CYC(GATE_CYC), .FS_CNT(FS_CNT)) u_pulse (
    .clk      (clk),
    .rst      (rst),
    .pulse_in (pulse_train_input),
    .pct      (pulse_pct)
  );

  always_comb begin
    src_tab = '{default: 16'sh0000};
    src_tab[`PIDC_SRC_KEYPAD] = keypad_ref_ff;
    src_tab[`PIDC_SRC_V1]     = first_voltage_input;
    src_tab[`PIDC_SRC_V2]     = second_voltage_input;
    src_tab[`PIDC_SRC_I2]     = current_input;
    src_tab[`PIDC_SRC_RS485]  = serial_input;
    src_tab[`PIDC_SRC_OPT]    = option_card_source;
    src_tab[`PIDC_SRC_USEQ]   = user_sequence_source;
    src_tab[`PIDC_SRC_PULSE]  = $signed(pulse_pct);
  end
  wire signed [15:0] ref_val = src_tab[reference_selector_param_ff];
  wire signed [15:0] fb_val  = src_tab[feedback_selector_param_ff];

  // APB decode and write checks.
  wire        setup   = psel & ~penable;
  wire        wr_acc  = psel & penable & pwrite & pready_ff;
  wire        wr_ok   = wr_acc & ~pslverr_ff;
  wire [3:0]  wsel    = pwdata[3:0];
  wire        sel_hi0 = (pwdata[31:4] == 28'h0000000);
  wire        hi_zero = (pwdata[31:16] == 16'h0000);
  wire        h_ref   = (paddr == `PIDC_A_REF_SEL);
  wire        h_fb    = (paddr == `PIDC_A_FB_SEL);
  wire        h_kr    = (paddr == `PIDC_A_KEY_REF);
  wire        h_pg    = (paddr == `PIDC_A_P_GAIN);
  wire        h_ps    = (paddr == `PIDC_A_P_SCALE);
  wire        h_it    = (paddr == `PIDC_A_I_TIME);
  wire        h_dt    = (paddr == `PIDC_A_D_TIME);
  wire        h_mfi   = (paddr == `PIDC_A_MFI_CFG);
  wire        h_st    = (paddr == `PIDC_A_STATUS);
  wire        h_out   = (paddr == `PIDC_A_OUT);
  wire        mapped  = h_ref | h_fb | h_kr | h_pg | h_ps | h_it | h_dt | h_mfi | h_st | h_out;
  wire        ref_ok  = src_ok(wsel) & sel_hi0;
  wire        fb_ok   = ref_ok & (wsel != `PIDC_SRC_KEYPAD) & (wsel != reference_selector_param_ff);
  wire        gain_ok  = hi_zero & (pwdata[15:0] <= `PIDC_GAIN_MAX);
  wire        scale_ok = hi_zero & (pwdata[15:0] <= `PIDC_SCALE_MAX);
  wire        bad_wr  = (h_ref & ~ref_ok) | (h_fb & ~fb_ok) | (h_pg & ~gain_ok) | (h_ps & ~scale_ok)
                        | h_st | h_out;
  wire        err_now = ~mapped | (pwrite & bad_wr);
  wire        busy    = (st_ff != ST_IDLE);
  wire [31:0] rd_mux  =
    h_ref ? {28'h0000000, reference_selector_param_ff} :
    h_fb  ? {28'h0000000, feedback_selector_param_ff} :
    h_kr  ? {{16{keypad_ref_ff[15]}}, keypad_ref_ff} :
    h_pg  ? {16'h0000, proportional_gain_ff} :
    h_ps  ? {16'h0000, gain_scale_ff} :
    h_it  ? {16'h0000, integral_time_ff} :
    h_dt  ? {16'h0000, derivative_time_ff} :
    h_mfi ? {19'h00000, mfi_func_ff, 5'h00, mfi_term_ff} :
    h_st  ? {30'h00000000, busy, refused_ff} :
    h_out ? pid_out_ff : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & err_now;
      if (setup && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_selector_param_ff <= `PIDC_SRC_KEYPAD;
      feedback_selector_param_ff  <= `PIDC_RST_FB_SEL;
      keypad_ref_ff        <= 16'sh0000;
      proportional_gain_ff <= `PIDC_RST_GAIN;
      gain_scale_ff        <= `PIDC_RST_SCALE;
      integral_time_ff     <= `PIDC_RST_I_TIME;
      derivative_time_ff   <= `PIDC_RST_D_TIME;
      mfi_term_ff          <= `PIDC_MFI_NONE;
      mfi_func_ff          <= 5'h00;
    end else if (wr_ok) begin
      if (h_ref) reference_selector_param_ff <= wsel;
      if (h_fb)  feedback_selector_param_ff  <= wsel;
      if (h_kr)  keypad_ref_ff        <= pwdata[15:0];
      if (h_pg)  proportional_gain_ff <= pwdata[15:0];
      if (h_ps)  gain_scale_ff        <= pwdata[15:0];
      if (h_it)  integral_time_ff     <= pwdata[15:0];
      if (h_dt)  derivative_time_ff   <= pwdata[15:0];
      if (h_mfi) mfi_term_ff          <= pwdata[2:0];
      if (h_mfi) mfi_func_ff          <= pwdata[12:8];
    end
  end

  wire nxt_refused = (wr_acc & h_fb & ~fb_ok) | (refused_ff & ~(wr_ok & h_fb));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= nxt_refused;
    end
  end

  wire tick_wrap = (tcnt_ff == TW'(TICK_CYC - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tcnt_ff <= tick_wrap ? '0 : tcnt_ff + 1'b1;
      tick_ff <= tick_wrap;
    end
  end

  // Control datapath, all from reference minus feedback.
  wire signed [16:0] err     = 17'(ref_val) - 17'(fb_val);
  wire signed [17:0] derr    = 18'(err) - 18'(err_prev_ff);
  wire signed [32:0] acc_sum = 33'(acc_ff) + 33'(err);
  wire               acc_ovf = (acc_sum[32] != acc_sum[31]);
  wire signed [31:0] acc_sat = acc_ovf ? (acc_sum[32] ? 32'sh80000000 : 32'sh7FFFFFFF) : acc_sum[31:0];
  wire               iclr    = (mfi_term_ff < 3'(MFI_N)) && mfi_in[mfi_term_ff] && (mfi_func_ff == `PIDC_MFI_ICLR);
  wire signed [31:0] acc_new = iclr ? 32'sh00000000 : acc_sat;
  wire        [31:0] acc_mag = acc_new[31] ? 32'(-acc_new) : 32'(acc_new);
  wire               go      = tick_ff & (st_ff == ST_IDLE);
  wire signed [47:0] p_prod  = 48'(err) * 48'($signed({1'b0, proportional_gain_ff}))
                               * 48'($signed({1'b0, gain_scale_ff}));
  wire signed [47:0] d_prod  = 48'(derr) * 48'($signed({1'b0, derivative_time_ff}));
  wire signed [47:0] i_mag   = 48'($signed({1'b0, quo}));
  wire signed [49:0] sum     = 50'(p_term_ff) + 50'(i_term_ff) + 50'(d_term_ff);

  pidc_divider #(.NW(32), .DW(16)) u_div (
    .clk      (clk),
    .rst      (rst),
    .start    (go),
    .dividend (acc_mag),
    .divisor  (integral_time_ff),
    .quotient (quo),
    .done     (div_done)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: nxt_st = go ? ST_WAIT : ST_IDLE;
      ST_WAIT: nxt_st = div_done ? ST_SUM : ST_WAIT;
      ST_SUM:  nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= 32'sh00000000;
    end else if (iclr || go) begin
      acc_ff <= acc_new;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= ST_IDLE;
      err_prev_ff <= 17'sh00000;
      p_term_ff   <= 48'sh000000000000;
      i_term_ff   <= 48'sh000000000000;
      d_term_ff   <= 48'sh000000000000;
      neg_ff      <= 1'b0;
      itime_go_ff <= 16'h0000;
      amag_go_ff  <= 32'h00000000;
      pid_out_ff  <= 32'sh00000000;
      valid_ff    <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      valid_ff <= (st_ff == ST_SUM);
      if (go) begin
        err_prev_ff <= err;
        p_term_ff   <= p_prod / `PIDC_GAIN_DIV;
        d_term_ff   <= d_prod;
        neg_ff      <= acc_new[31];
        itime_go_ff <= integral_time_ff;
        amag_go_ff  <= acc_mag;
      end
      if (st_ff == ST_WAIT && div_done) begin
        // The divisor latched at period start decides, so a mid-period write cannot spike the term.
        i_term_ff <= (itime_go_ff == 16'h0000) ? 48'sh000000000000 : (neg_ff ? -i_mag : i_mag);
      end
      if (st_ff == ST_SUM) begin
        pid_out_ff <= sat32(sum);
      end
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign pid_out   = pid_out_ff;
  assign pid_valid = valid_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_keypad_ref;
    (reference_selector_param_ff == `PIDC_SRC_KEYPAD) |-> (ref_val == keypad_ref_ff);
  endproperty
  a_keypad_ref: assert property (p_keypad_ref) else $error("keypad reference not used");
  property p_serial_ref;
    (reference_selector_param_ff == `PIDC_SRC_RS485) |-> (ref_val == serial_input);
  endproperty
  a_serial_ref: assert property (p_serial_ref) else $error("serial reference not used");
  property p_pulse_ref;
    (reference_selector_param_ff == `PIDC_SRC_PULSE) |-> (ref_val == $signed(pulse_pct));
  endproperty
  a_pulse_ref: assert property (p_pulse_ref) else $error("pulse reference not used");
  property p_fb_not_keypad;
    feedback_selector_param_ff != `PIDC_SRC_KEYPAD;
  endproperty
  a_fb_not_keypad: assert property (p_fb_not_keypad) else $error("keypad chosen as feedback");
  property p_fb_distinct;
    (wr_acc && h_fb && wsel == reference_selector_param_ff) |=> ($stable(feedback_selector_param_ff) && refused_ff);
  endproperty
  a_fb_distinct: assert property (p_fb_distinct) else $error("same source accepted as feedback");
  property p_unity_gain;
    (go && proportional_gain_ff == 16'h03E8 && gain_scale_ff == 16'h03E8) |=> (p_term_ff == 48'($past(err)));
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("proportional term wrong at 100 percent");
  property p_gain_limit;
    (wr_acc && h_pg && pwdata[15:0] > `PIDC_GAIN_MAX) |=> $stable(proportional_gain_ff);
  endproperty
  a_gain_limit: assert property (p_gain_limit) else $error("gain above range accepted");
  property p_integral_div;
    (st_ff == ST_WAIT && div_done && itime_go_ff != 16'h0000)
      |-> ((48'(quo) * 48'(itime_go_ff)) <= 48'(amag_go_ff))
          && (((48'(quo) + 48'h000000000001) * 48'(itime_go_ff)) > 48'(amag_go_ff));
  endproperty
  a_integral_div: assert property (p_integral_div) else $error("integral term not acc over time");
  property p_iclr;
    iclr |=> (acc_ff == 32'sh00000000);
  endproperty
  a_iclr: assert property (p_iclr) else $error("integral not cleared");
  property p_deriv;
    (go && derivative_time_ff == 16'h0001) |=> (d_term_ff == 48'($past(derr)));
  endproperty
  a_deriv: assert property (p_deriv) else $error("derivative term wrong");
  sequence s_period_start;
    go;
  endsequence
  sequence s_period_end;
    ##[1:40] valid_ff;
  endsequence
  property p_period;
    s_period_start |-> s_period_end;
  endproperty
  a_period: assert property (p_period) else $error("output not produced in period");
  property p_sum;
    (st_ff == ST_SUM) |=> (pid_out_ff == sat32(50'($past(p_term_ff)) + 50'($past(i_term_ff)) + 50'($past(d_term_ff))));
  endproperty
  a_sum: assert property (p_sum) else $error("output is not sum of terms");
endmodule

// ==== dv/pidc_field_model.sv ====
// Purpose: Model of the process side: source levels, pulse train and multi-function terminals.
// Assumes: The bench sets the reference and feedback levels and the terminal requests.
// Notes: Outputs change only right after a rising clock edge.
`timescale 1ns/1ps
module pidc_field_model
  import pidc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic signed [15:0] ref_lvl,
  input  wire logic signed [15:0] fb_lvl,
  input  wire logic        [6:0] mfi_req,
  output logic signed     [15:0] v1,
  output logic signed     [15:0] v2,
  output logic signed     [15:0] ci,
  output logic signed     [15:0] si,
  output logic signed     [15:0] oc,
  output logic signed     [15:0] us,
  output logic                   pt,
  output logic             [6:0] mfi
);
  logic [4:0] pcnt_ff;
  // RS-485, option card and user sequence get offsets 0, 1 and 2 from ref_lvl so a wrong select shows up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {v1, v2, ci, si, oc, us} <= '0;
      pt      <= 1'b0;
      mfi     <= 7'h00;
      pcnt_ff <= 5'h00;
    end else begin
      v1      <= fb_lvl;
      v2      <= fb_lvl;
      ci      <= fb_lvl;
      si      <= ref_lvl;
      oc      <= ref_lvl + 16'sh0001;
      us      <= ref_lvl + 16'sh0002;
      mfi     <= mfi_req;
      pcnt_ff <= pcnt_ff + 5'h01;
      pt      <= pcnt_ff[4];
    end
  end
endmodule

// ==== dv/test_pid_process_controller.sv ====
// Purpose: Self-checking bench for the PID controller through APB and its output port.
// Assumes: One control period is 100 clocks in this bench.
// Notes: Expected outputs are worked out from the control equations.
`timescale 1ns/1ps
`include "pidc_defs.svh"
module test_pid_process_controller
  import pidc_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic         [7:0] paddr = 8'h00;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic        [31:0] pwdata = 32'h0;
  logic signed [15:0] ref_lvl = 16'sh0;
  logic signed [15:0] fb_lvl = 16'sh0;
  logic         [6:0] mfi_req = 7'h00;
  wire         [31:0] prdata;
  wire                pready, pslverr, pt, pid_valid;
  wire signed  [15:0] v1, v2, ci, si, oc, us;
  wire          [6:0] mfi;
  wire signed  [31:0] pid_out;
  int                 n_mismatch = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  logic        [31:0] rd;
  logic               er;

  always #12.5 clk = ~clk;

  pidc_field_model PM (.clk(clk), .rst(rst), .ref_lvl(ref_lvl), .fb_lvl(fb_lvl), .mfi_req(mfi_req),
    .v1(v1), .v2(v2), .ci(ci), .si(si), .oc(oc), .us(us), .pt(pt), .mfi(mfi));

  pidc_top #(.TICK_CYC(100), .GATE_CYC(1000)) DUT (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_voltage_input(v1), .second_voltage_input(v2), .current_input(ci),
    .serial_input(si), .option_card_source(oc), .user_sequence_source(us), .pulse_train_input(pt),
    .mfi_in(mfi), .pid_out(pid_out), .pid_valid(pid_valid));

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, e});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_valid(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(posedge clk); k++; end while (pid_valid !== 1'b1 && k < 500);
      chk({31'h0, pid_valid}, 32'h1);
    end
  endtask

  task automatic t_regs();
    rdc(`PIDC_A_REF_SEL, 32'h0);
    rdc(`PIDC_A_FB_SEL, 32'h1);
    rdc(`PIDC_A_P_GAIN, 32'h1F4);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(`PIDC_A_OUT, 32'h5, 1'b1);
  endtask

  task automatic t_fb_refuse();
    wr(`PIDC_A_REF_SEL, 32'h3, 1'b0);
    wr(`PIDC_A_FB_SEL, 32'h3, 1'b1);
    rdc(`PIDC_A_FB_SEL, 32'h1);
    apb(1'b0, `PIDC_A_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    wr(`PIDC_A_FB_SEL, 32'h0, 1'b1);
    wr(`PIDC_A_FB_SEL, 32'h4, 1'b0);
  endtask

  task automatic t_prop();
    wr(`PIDC_A_REF_SEL, 32'h0, 1'b0);
    wr(`PIDC_A_FB_SEL, 32'h1, 1'b0);
    wr(`PIDC_A_KEY_REF, 32'h3E8, 1'b0);
    wr(`PIDC_A_I_TIME, 32'h0, 1'b0);
    wr(`PIDC_A_P_GAIN, 32'h2711, 1'b1);
    wait_valid(2);
    chk(pid_out, 32'h1F4);
    wr(`PIDC_A_P_SCALE, 32'h64, 1'b0);
    wait_valid(2);
    chk(pid_out, 32'h32);
    wr(`PIDC_A_P_SCALE, 32'h3E8, 1'b0);
  endtask

  task automatic t_sel();
    logic [3:0] sel [3] = '{4'h5, 4'h7, 4'h9};
    wr(`PIDC_A_P_GAIN, 32'h3E8, 1'b0);
    ref_lvl <= 16'sh07D0;
    foreach (sel[i]) begin
      wr(`PIDC_A_REF_SEL, {28'h0, sel[i]}, 1'b0);
      wait_valid(2);
      chk(pid_out, 32'h7D0 + i);
    end
  endtask

  task automatic t_int();
    int i;
    wr(`PIDC_A_REF_SEL, 32'h0, 1'b0);
    wr(`PIDC_A_P_GAIN, 32'h0, 1'b0);
    wr(`PIDC_A_KEY_REF, 32'h2710, 1'b0);
    wr(`PIDC_A_MFI_CFG, 32'h1502, 1'b0);
    wr(`PIDC_A_I_TIME, 32'h4, 1'b0);
    mfi_req <= 7'h04;
    wait_valid(3);
    chk(pid_out, 32'h0);
    mfi_req <= 7'h00;
    for (i = 1; i <= 4; i++) begin
      wait_valid(1);
      chk(pid_out, 2500 * i);
    end
  endtask

  task automatic t_der();
    wr(`PIDC_A_I_TIME, 32'h0, 1'b0);
    wr(`PIDC_A_D_TIME, 32'h2, 1'b0);
    ref_lvl <= 16'sh0;
    wr(`PIDC_A_REF_SEL, 32'h5, 1'b0);
    wait_valid(2);
    ref_lvl <= 16'sh012C;
    wait_valid(1);
    chk(pid_out, 32'h258);
    wait_valid(1);
    chk(pid_out, 32'h0);
  endtask

  // About 31.25 edges per gate give 96 or 100 percent units depending on phase.
  task automatic t_pulse();
    wr(`PIDC_A_D_TIME, 32'h0, 1'b0);
    wr(`PIDC_A_P_GAIN, 32'h3E8, 1'b0);
    wr(`PIDC_A_REF_SEL, 32'hB, 1'b0);
    wait_valid(2);
    chk({31'h0, ($signed(pid_out) >= 32'sh60 && $signed(pid_out) <= 32'sh64)}, 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_fb_refuse();
    t_prop();
    t_sel();
    t_int();
    t_der();
    t_pulse();
    stop_test();
  end
endmodule
